// ---- hw/qd_ctrl.sv ----
// Operation
// RULE_01 - Async update pin refreshes all outputs
// RULE_02 - Host keeps select high during async update
// RULE_03 - Host keeps async pin high in readback
// RULE_04 - Select active low gates all serial activity
// RULE_05 - Data most significant first after 4/6 bits
// RULE_06 - Readback needs exactly seven instruction bits
// RULE_07 - Readback bit order and edge selectable
// RULE_08 - Supply interruption pulls open-drain flag low
// RULE_09 - Each channel: shift, input, converter register (code shares one shift register across all channels)
// RULE_10 - Async falling edge copies inputs to converters
// RULE_11 - Converter registers clear at power-up
// RULE_12 - Channel bits pick the written input register
// RULE_13 - Update bit commits on select rising edge
// RULE_14 - Sample serial input on clock rising edge
`timescale 1ns/10ps
`default_nettype none
module qd_ctrl
   import qd_pkg::*;
#(
   parameter int FIFO_DEPTH = QD_FIFO_DEPTH
) (
   input  wire logic  clk,
   input  wire logic  rst,
   input  wire logic  cs_n,
   input  wire logic  sclk,
   input  wire logic  sdi,
   input  wire logic  async_update_n,
   input  wire logic  supply_ok,
   output logic       sdo,
   output logic       sdo_oe,
   output logic       pwr_fail_o,
   output logic       pwr_fail_oe,
   output qd_bank_t   dac_code,
   output logic       wr_overflow
);
   // ------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ------------------------------------------------------------
   logic       cs_n_s, sclk_s, sdi_s, au_n_s, supply_s;
   logic       sclk_d_reg, cs_d_reg, au_d_reg;
   logic       sclk_rise, sclk_fall, cs_rise, au_fall;

   qd_sync #(
      .W       (QD_NSYNC),
      .RST_VAL (QD_SYNC_IDLE)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({supply_ok, async_update_n, sdi, sclk, cs_n}),
      .q   ({supply_s, au_n_s, sdi_s, sclk_s, cs_n_s})
   );

   // Previous levels, taken from the second sync stage only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_d_reg <= 1'b0;
         cs_d_reg   <= 1'b1;
         au_d_reg   <= 1'b1;
      end else begin
         sclk_d_reg <= sclk_s;
         cs_d_reg   <= cs_n_s;
         au_d_reg   <= au_n_s;
      end
   end
   assign sclk_rise = sclk_s && !sclk_d_reg;
   assign sclk_fall = !sclk_s && sclk_d_reg;
   assign cs_rise   = cs_n_s && !cs_d_reg;
   assign au_fall   = !au_n_s && au_d_reg;

   // ------------------------------------------------------------
   // Instruction decoding helpers
   // ------------------------------------------------------------
   function automatic logic [QD_CNTW-1:0] instr_last(input logic [QD_CMDW-1:0] c);
      if (c[QD_B_RW])
         instr_last = QD_LAST_RD;
      else if (c[QD_B_G])
         instr_last = QD_LAST_WG;
      else
         instr_last = QD_LAST_WS;
   endfunction : instr_last

   function automatic logic [QD_CHW-1:0] pick_chan(input logic [QD_CMDW-1:0] c);
      if (c[QD_B_G])
         pick_chan = QD_CH_FIRST; // Global traffic always starts at channel 1
      else
         pick_chan = c[QD_B_RW] ? {c[QD_B_A1R], c[QD_B_A0R]} : {c[QD_B_A1W], c[QD_B_A0W]};
   endfunction : pick_chan

   // ------------------------------------------------------------
   // Serial engine state
   // ------------------------------------------------------------
   qd_state_e             state_reg, state_next;
   logic [QD_CNTW-1:0]    bitcnt_reg, bitcnt_next;
   logic [QD_CMDW-1:0]    cmd_reg, cmd_next, cmd_now;
   logic [QD_DW-1:0]      shift_reg, shift_next, shift_now;
   logic [QD_DW-1:0]      word_reg, word_next;
   logic [QD_CHW-1:0]     ch_reg, ch_next;
   logic [QD_NCH-1:0]     mask_reg, mask_next, pend_set;
   logic                  skip_reg, skip_next;
   logic                  sdo_reg, sdo_next, oe_reg, oe_next;
   logic                  ovf_reg, ovf_next;
   logic                  rd_edge, push;
   qd_bank_t              in_reg, in_next, dac_reg, dac_next;
   logic [QD_NCH-1:0]     pend_reg, pend_next;
   logic                  fifo_in_ready, fifo_out_valid, pop_ready;
   logic [QD_CHW+QD_DW-1:0] fifo_out;
   logic [QD_CHW-1:0]     pop_ch;
   logic [QD_DW-1:0]      pop_data;
   logic                  pop_fire, apply_pend;
   logic                  pf_reg, pf_next;

   assign cmd_now   = cmd_reg | (QD_CMDW'(sdi_s) << bitcnt_reg);
   assign shift_now = {shift_reg[QD_DW-2:0], sdi_s};
   assign rd_edge   = cmd_reg[QD_B_RF] ? sclk_rise : sclk_fall; // [RULE_07]

   // Next state of the serial engine
   always_comb begin
      state_next  = state_reg;
      bitcnt_next = bitcnt_reg;
      cmd_next    = cmd_reg;
      shift_next  = shift_reg;
      word_next   = word_reg;
      ch_next     = ch_reg;
      mask_next   = mask_reg;
      skip_next   = skip_reg;
      sdo_next    = sdo_reg;
      oe_next     = oe_reg;
      ovf_next    = 1'b0;
      push        = 1'b0;
      pend_set    = '0;
      if (cs_n_s) begin
         // Deselected: everything idles and output floats [RULE_04]
         state_next  = QD_IDLE;
         bitcnt_next = '0;
         oe_next     = 1'b0;
         mask_next   = '0;
         if (cs_rise && !cmd_reg[QD_B_RW] && cmd_reg[QD_B_U])
            pend_set = mask_reg; // [RULE_13]
      end else begin
         unique case (state_reg)
            QD_IDLE: begin
               // Wait for the start marker on a rising edge [RULE_14]
               if (sclk_rise && sdi_s) begin
                  state_next  = QD_CMD;
                  bitcnt_next = '0;
                  cmd_next    = '0;
               end
            end
            QD_CMD: begin
               if (sclk_rise) begin
                  cmd_next    = cmd_now;
                  bitcnt_next = bitcnt_reg + 4'h1;
                  // Length of the instruction depends on its own bits [RULE_05] [RULE_06]
                  if (bitcnt_reg == instr_last(cmd_now)) begin
                     bitcnt_next = '0;
                     if (cmd_now[QD_B_RW]) begin
                        state_next = QD_RDATA;
                        ch_next    = pick_chan(cmd_now);
                        word_next  = in_reg[pick_chan(cmd_now)];
                        skip_next  = 1'b1;
                     end else begin
                        state_next = QD_WDATA;
                        ch_next    = cmd_now[QD_B_G] ? QD_CH_FIRST : pick_chan(cmd_now); // [RULE_12]
                     end
                  end
               end
            end
            QD_WDATA: begin
               if (sclk_rise) begin
                  shift_next  = shift_now; // [RULE_05]
                  bitcnt_next = bitcnt_reg + 4'h1;
                  if (bitcnt_reg == QD_DW_LAST) begin
                     push        = 1'b1;
                     bitcnt_next = '0;
                     ch_next     = ch_reg + 2'h1;
                     if (fifo_in_ready)
                        mask_next[ch_reg] = 1'b1;
                     else
                        ovf_next = 1'b1;
                     if (!cmd_reg[QD_B_G] || ch_reg == QD_CH_LAST)
                        state_next = QD_HOLD;
                  end
               end
            end
            QD_RDATA: begin
               if (rd_edge) begin
                  if (skip_reg) begin
                     // First selected edge after the instruction is a gap
                     skip_next = 1'b0;
                  end else begin
                     oe_next     = 1'b1;
                     sdo_next    = cmd_reg[QD_B_ML] ? word_reg[QD_DW-1] : word_reg[0]; // [RULE_07]
                     word_next   = cmd_reg[QD_B_ML] ? {word_reg[QD_DW-2:0], 1'b0}
                                                    : {1'b0, word_reg[QD_DW-1:1]};
                     bitcnt_next = bitcnt_reg + 4'h1;
                     if (bitcnt_reg == QD_DW_LAST) begin
                        bitcnt_next = '0;
                        if (cmd_reg[QD_B_G] && ch_reg != QD_CH_LAST) begin
                           ch_next   = ch_reg + 2'h1;
                           word_next = in_reg[ch_reg + 2'h1];
                        end else begin
                           state_next = QD_HOLD;
                        end
                     end
                  end
               end
            end
            QD_HOLD: begin
               // Ignore further clocks until select is released
            end
            default: begin
               state_next = QD_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg  <= QD_IDLE;
         bitcnt_reg <= '0;
         cmd_reg    <= '0;
         shift_reg  <= '0;
         word_reg   <= '0;
         ch_reg     <= '0;
         mask_reg   <= '0;
         skip_reg   <= 1'b0;
         sdo_reg    <= 1'b0;
         oe_reg     <= 1'b0;
         ovf_reg    <= 1'b0;
      end else begin
         state_reg  <= state_next;
         bitcnt_reg <= bitcnt_next;
         cmd_reg    <= cmd_next;
         shift_reg  <= shift_next;
         word_reg   <= word_next;
         ch_reg     <= ch_next;
         mask_reg   <= mask_next;
         skip_reg   <= skip_next;
         sdo_reg    <= sdo_next;
         oe_reg     <= oe_next;
         ovf_reg    <= ovf_next;
      end
   end

   // ------------------------------------------------------------
   // Word buffer between the serial side and the input registers
   // ------------------------------------------------------------
   // Draining stalls in the async copy cycle so that copy and input-register write never race
   assign pop_ready = !au_fall;

   qd_fifo #(
      .W     (QD_CHW + QD_DW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   ({ch_reg, shift_now}),
      .out_valid (fifo_out_valid),
      .out_ready (pop_ready),
      .out_data  (fifo_out)
   );
   assign pop_ch     = fifo_out[QD_CHW+QD_DW-1:QD_DW];
   assign pop_data   = fifo_out[QD_DW-1:0];
   assign pop_fire   = fifo_out_valid && pop_ready;
   // Select-release update waits until every earlier word has landed
   assign apply_pend = !fifo_out_valid && (pend_reg != '0);

   // ------------------------------------------------------------
   // Input, converter and pending-update registers
   // ------------------------------------------------------------
   always_comb begin
      in_next   = in_reg;
      dac_next  = dac_reg;
      pend_next = pend_reg | pend_set;
      if (pop_fire)
         in_next[pop_ch] = pop_data; // [RULE_09] [RULE_12]
      if (au_fall) begin
         // Whole bank at once, no serial traffic involved [RULE_01] [RULE_10]
         dac_next  = in_reg;
         pend_next = pend_set;
      end else if (apply_pend) begin
         for (int i = 0; i < QD_NCH; i++) begin
            if (pend_reg[i])
               dac_next[i] = in_reg[i]; // [RULE_13]
         end
         pend_next = pend_set; // A new set wins over the clear
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in_reg   <= '0;
         dac_reg  <= '0; // [RULE_11]
         pend_reg <= '0;
      end else begin
         in_reg   <= in_next;
         dac_reg  <= dac_next;
         pend_reg <= pend_next;
      end
   end

   // ------------------------------------------------------------
   // Power-fail flag, sticky until the next power-up reset
   // ------------------------------------------------------------
   assign pf_next = pf_reg || !supply_s; // [RULE_08]
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         pf_reg <= 1'b0;
      else
         pf_reg <= pf_next;
   end

   assign sdo         = sdo_reg;
   assign sdo_oe      = oe_reg;
   assign pwr_fail_o  = 1'b0;   // Open drain: only ever pulls low
   assign pwr_fail_oe = pf_reg;
   assign dac_code    = dac_reg;
   assign wr_overflow = ovf_reg;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_cmd_done;
      state_reg == QD_CMD ##1 state_reg == QD_RDATA;
   endsequence
   sequence s_first_bit;
      state_reg == QD_RDATA && skip_reg && rd_edge && !cs_n_s;
   endsequence

   a_async_copy: assert property (au_fall |=> dac_reg == $past(in_reg)) // [RULE_10]
      else $error("async update did not copy input bank");
   a_deselect_idle: assert property (cs_n_s |=> state_reg == QD_IDLE && !sdo_oe) // [RULE_04]
      else $error("engine active while deselected");
   a_read_len: assert property (s_cmd_done |-> $past(bitcnt_reg) == QD_LAST_RD) // [RULE_06]
      else $error("readback entered with wrong instruction length");
   a_write_len: assert property ($rose(state_reg == QD_WDATA) |->
                                 $past(bitcnt_reg) == ($past(cmd_now[QD_B_G]) ? QD_LAST_WG : QD_LAST_WS)) // [RULE_05]
      else $error("write entered with wrong instruction length");
   a_read_gap: assert property (s_first_bit |=> !sdo_oe) // [RULE_07]
      else $error("output driven on the skipped edge");
   a_pf_flag: assert property (!supply_s |=> pwr_fail_oe ##1 pwr_fail_oe) // [RULE_08]
      else $error("power-fail flag not pulled low");
   a_upd_commit: assert property (apply_pend && !au_fall |=> (pend_reg & $past(pend_reg)) == '0) // [RULE_13]
      else $error("pending update not committed");
   a_chan_write: assert property (pop_fire |=> in_reg[$past(pop_ch)] == $past(pop_data)) // [RULE_12]
      else $error("word not stored in selected input register");
endmodule : qd_ctrl
`default_nettype wire

// ---- pkg/qd_pkg.sv ----
`default_nettype none
package qd_pkg;
   // ------------------------------------------------------------
   // Channel and word geometry
   // ------------------------------------------------------------
   localparam int              QD_NCH        = 4;
   localparam int              QD_DW         = 10;
   localparam int              QD_CHW        = 2;
   localparam int              QD_CNTW       = 4;
   localparam int              QD_CMDW       = 6;
   localparam int              QD_FIFO_DEPTH = 4;
   localparam logic [QD_CNTW-1:0] QD_DW_LAST = 4'h9;
   localparam logic [QD_CHW-1:0]  QD_CH_LAST = 2'h3;
   localparam logic [QD_CHW-1:0]  QD_CH_FIRST = 2'h0;

   // ------------------------------------------------------------
   // Instruction bit positions, counted after the start marker
   // ------------------------------------------------------------
   localparam int QD_B_RW  = 0;  // 1 = readback
   localparam int QD_B_G   = 1;  // Global (all channels)
   localparam int QD_B_U   = 2;  // Write: update on select release
   localparam int QD_B_RF  = 2;  // Read: output changes on rising edge
   localparam int QD_B_ML  = 3;  // Read: most significant bit first
   localparam int QD_B_A1W = 3;
   localparam int QD_B_A0W = 4;
   localparam int QD_B_A1R = 4;
   localparam int QD_B_A0R = 5;
   // Index of the last instruction bit for each command kind
   localparam logic [QD_CNTW-1:0] QD_LAST_RD = 4'h5;
   localparam logic [QD_CNTW-1:0] QD_LAST_WS = 4'h4;
   localparam logic [QD_CNTW-1:0] QD_LAST_WG = 4'h2;

   // ------------------------------------------------------------
   // Pin synchroniser order and idle levels
   // ------------------------------------------------------------
   localparam int          QD_NSYNC     = 5;
   localparam logic [4:0]  QD_SYNC_IDLE = 5'h19; // {supply_ok,au_n,sdi,sclk,cs_n}

   typedef logic [QD_NCH-1:0][QD_DW-1:0] qd_bank_t;
   typedef enum logic [2:0] {
      QD_IDLE  = 3'h0,
      QD_CMD   = 3'h1,
      QD_WDATA = 3'h3,
      QD_RDATA = 3'h5,
      QD_HOLD  = 3'h7
   } qd_state_e;
endpackage : qd_pkg
`default_nettype wire

// ---- hw/qd_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module qd_sync #(
   parameter int               W       = 1,
   parameter logic [W-1:0]     RST_VAL = '0
) (
   input  wire logic           clk,
   input  wire logic           rst,
   input  wire logic [W-1:0]   d,
   output logic [W-1:0]        q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   // Two stages per pin; only the second stage is read outside
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= RST_VAL;
         q_reg    <= RST_VAL;
      end else begin
         meta_reg <= d;
         q_reg    <= meta_reg;
      end
   end
   assign q = q_reg;
endmodule : qd_sync
`default_nettype wire

// ---- hw/qd_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
module qd_fifo #(
   parameter int W     = 12,
   parameter int DEPTH = 4
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          in_valid,
   output logic               in_ready,
   input  wire logic [W-1:0]  in_data,
   output logic               out_valid,
   input  wire logic          out_ready,
   output logic [W-1:0]       out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [DEPTH-1:0][W-1:0] mem_reg, mem_next;
   logic [AW-1:0]           wp_reg, wp_next, rp_reg, rp_next;
   logic [AW:0]             cnt_reg, cnt_next;
   logic                    push, pop;

   // Honest flags straight from the occupancy count
   assign in_ready  = (cnt_reg != FULL_CNT);
   assign out_valid = (cnt_reg != '0);
   assign out_data  = mem_reg[rp_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointer wrap at DEPTH, so odd depths work too
   always_comb begin
      mem_next = mem_reg;
      wp_next  = wp_reg;
      rp_next  = rp_reg;
      if (push) begin
         mem_next[wp_reg] = in_data;
         wp_next = (wp_reg == AW'(DEPTH - 1)) ? '0 : AW'(wp_reg + 1'b1);
      end
      if (pop) begin
         rp_next = (rp_reg == AW'(DEPTH - 1)) ? '0 : AW'(rp_reg + 1'b1);
      end
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_reg <= '0;
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         mem_reg <= mem_next;
         wp_reg  <= wp_next;
         rp_reg  <= rp_next;
         cnt_reg <= cnt_next;
      end
   end
endmodule : qd_fifo
`default_nettype wire

// ---- tb/qd_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// ------
// Host model on the serial port
// ------
module qd_host (
   input  wire logic clk,
   input  wire logic sdo,
   input  wire logic sdo_oe,
   output logic      cs_n,
   output logic      sclk,
   output logic      sdi,
   output logic      async_update_n
);
   logic      last_bit;
   wire logic line;

   // A released output shows the inverse of its last bit, never a held value
   assign line = sdo_oe ? sdo : ~last_bit;

   // Idle levels: select high, clock parked low
   initial begin
      cs_n           = 1'b1;
      sclk           = 1'b0;
      sdi            = 1'b0;
      async_update_n = 1'b1;
      last_bit       = 1'b0;
   end

   // One frame of n bits, first bit sent first; sel low keeps select high
   // Update pin stays high for the whole frame
   task automatic frame(input logic [63:0] bits, input int n, input logic sel, output logic [63:0] rx);
      rx = '0;
      cs_n <= ~sel;
      repeat (5) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         sdi <= bits[n-1-i];
         repeat (5) @(posedge clk);
         sclk <= 1'b1;
         repeat (5) @(posedge clk);
         rx = {rx[62:0], line};
         last_bit = line;
         sclk <= 1'b0;
      end
      repeat (5) @(posedge clk);
      cs_n <= 1'b1;
      sdi  <= 1'b0;
      // Long enough for the select-release commit to land
      repeat (12) @(posedge clk);
   endtask : frame

   // Update pulse, only ever issued with select high
   task automatic pulse_update();
      async_update_n <= 1'b0;
      repeat (8) @(posedge clk);
      async_update_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask : pulse_update
endmodule : qd_host
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench
   import qd_pkg::*;
   ;
   logic        clk, rst, supply_ok, sdo, sdo_oe, pwr_fail_o, pwr_fail_oe, wr_overflow;
   logic        cs_n, sclk, sdi, au_n;
   logic [63:0] rx;
   qd_bank_t    dac_code, in_m, dac_m;
   int          failures, total_checks;

   // ------
   // Clock and instances
   // ------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   qd_ctrl uut (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .async_update_n(au_n),
      .supply_ok(supply_ok), .sdo(sdo), .sdo_oe(sdo_oe), .pwr_fail_o(pwr_fail_o),
      .pwr_fail_oe(pwr_fail_oe), .dac_code(dac_code), .wr_overflow(wr_overflow));
   qd_host host (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
      .async_update_n(au_n));

   // ------
   // Checking helpers
   // ------
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test();
      if (failures == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test

   function automatic logic [9:0] rev10(input logic [9:0] v);
      for (int i = 0; i < 10; i++) rev10[i] = v[9-i];
   endfunction : rev10

   // The host never outruns the buffer, so no word may be dropped
   always @(posedge clk) begin
      if (!rst && wr_overflow !== 1'b0) check(wr_overflow, 1'b0);
   end

   // Watchdog: a hang ends the run as a failure
   initial begin
      repeat (90000) @(posedge clk);
      failures++;
      finish_test();
   end

   // ------
   // Transfers
   // ------
   // Single write, with leading zeros before the marker that must be skipped
   task automatic wr(input logic [1:0] ch, input logic u, input logic [9:0] d, input int pre,
                     input logic sel);
      host.frame({48'h0, 2'h2, 1'b0, u, ch, d}, 16 + pre, sel, rx);
      if (sel) begin
         in_m[ch] = d;
         if (u) dac_m[ch] = d;
      end
      check(dac_code, dac_m);
   endtask : wr

   // Global write, words for channel 1 first
   task automatic wr_all(input logic u, input logic [39:0] d);
      host.frame({20'h0, 3'h5, u, d}, 44, 1'b1, rx);
      for (int k = 0; k < 4; k++) in_m[k] = d[39-10*k -: 10];
      if (u) dac_m = in_m;
      check(dac_code, dac_m);
   endtask : wr_all

   // Readback; one gap edge, then bits in the chosen order
   task automatic rd(input logic g, input logic rf, input logic ml, input logic [1:0] ch);
      int          len;
      logic [39:0] exp;
      len = g ? 40 : 10;
      exp = '0;
      for (int k = 0; k < 4; k++) begin
         if (g || k == ch) exp = {exp[29:0], ml ? in_m[k] : rev10(in_m[k])};
      end
      host.frame({57'h0, 2'h3, g, rf, ml, ch} << (len + 1), len + 8, 1'b1, rx);
      check(g ? rx[39:0] : rx[9:0], exp);
      check(sdo_oe, 1'b0);
   endtask : rd

   // ------
   // Main sequence
   // ------
   initial begin
      rst = 1'b1;
      supply_ok = 1'b1;
      in_m = '0;
      dac_m = '0;
      failures = 0;
      total_checks = 0;
      void'($urandom(47));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      check(dac_code, '0);
      check(pwr_fail_oe, 1'b0);
      // Every channel, every order and edge choice, update on and off
      for (int i = 0; i < 8; i++) begin
         wr(2'(i), i[0], 10'($urandom), i % 3, 1'b1);
         rd(1'b0, i[1], i[2], 2'(i));
      end
      // Deselected traffic changes nothing
      wr(2'h1, 1'b1, 10'h2aa, 0, 1'b0);
      rd(1'b0, 1'b0, 1'b1, 2'h1);
      // Global write without update, corner words, then the async copy
      wr_all(1'b0, {10'h3ff, 10'h000, 10'h155, 10'($urandom)});
      rd(1'b1, 1'b0, 1'b1, 2'h2);
      rd(1'b1, 1'b1, 1'b0, 2'h2);
      host.pulse_update();
      dac_m = in_m;
      check(dac_code, dac_m);
      wr_all(1'b1, {$urandom, 8'($urandom)});
      // Supply dip raises the sticky flag
      supply_ok <= 1'b0;
      repeat (4) @(posedge clk);
      supply_ok <= 1'b1;
      repeat (10) @(posedge clk);
      check(pwr_fail_oe, 1'b1);
      check(pwr_fail_o, 1'b0);
      // Cut frame: the partial word is dropped and its update bit does nothing
      host.frame({52'h0, 2'h2, 1'b0, 1'b1, 2'h0, 6'h3f}, 12, 1'b1, rx);
      check(dac_code, dac_m);
      check(wr_overflow, 1'b0);
      rd(1'b0, 1'b1, 1'b1, 2'h0);
      // Buffer order: the four words of a global write land channel 1 first
      wr_all(1'b1, {10'h001, 10'h002, 10'h200, 10'h3fe});
      for (int k = 0; k < 4; k++) begin
         check(dac_code[k], dac_m[k]);
      end
      finish_test();
   end
endmodule : testbench
`default_nettype wire
